/* logic/isvl_core.sv */
// interrupt source capture, arbitration and vector selection beside the cpu core
`timescale 1ns/1ps
module isvl_core (
	// clock and reset
	input  wire logic                           core_clk,
	input  wire logic                           rstn,
	// pins and special sources
	input  wire logic                           extNmiPinN,
	input  wire logic                           supplyAboveThreshold,
	input  wire logic                           watchdogUnderflow,
	input  wire logic                           mainClockLost,
	// peripheral sources and their control bits
	input  wire logic [63:0]                    periEvent,
	input  wire isvl_pkg::isvl_serial_t         serialEvent,
	input  wire logic [43:8][2:0]               sourcePriorityLevel,
	input  wire logic [63:0]                    requestFlagClear,
	input  wire logic                           serial03VectorSelect,
	input  wire logic                           serial14VectorSelect,
	input  wire logic                           fastIrqSelect,
	input  wire logic [23:0]                    vectorBase,
	input  wire logic [23:0]                    fastVector,
	input  wire logic [7:0]                     addrMatchEnableReg,
	input  wire logic [7:0][23:0]               addrMatchTarget,
	// cpu core side
	input  wire logic                           instrBoundary,
	input  wire logic [23:0]                    nextPc,
	input  wire isvl_pkg::isvl_trap_t           trapKind,
	input  wire logic [5:0]                     trapNum,
	input  wire logic                           globalEnable,
	input  wire logic [2:0]                     currentPriorityLevel,
	input  wire logic [isvl_pkg::FLAG_W-1:0]    flagIn,
	input  wire logic                           fastReturnInstr,
	// vector byte fetch
	output logic                                memRdReq,
	output logic [23:0]                         memAddr,
	input  wire logic [7:0]                     memRdata,
	input  wire logic                           memRdAck,
	// results
	output logic                                busy,
	output logic                                entryDone,
	output logic [23:0]                         entryTarget,
	output logic                                entryFast,
	output logic                                entryIplLoad,
	output logic [2:0]                          entryIpl,
	output logic [1:0]                          specialCause,
	output logic                                returnDone,
	output logic [isvl_pkg::FLAG_W-1:0]         savedFlags,
	output logic [23:0]                         savedPc,
	output logic [63:0]                         requestFlag,
	output logic                                dma23Disable
);
	isvl_pkg::isvl_regs_t r;
	isvl_pkg::isvl_regs_t rNext;

	// maps raw source lines onto relocatable numbers; reserved numbers stay low
	function automatic logic [63:0] mapEvents(input logic [63:0] pe,
		input isvl_pkg::isvl_serial_t s, input logic sel03, input logic sel14);
		logic [63:0] v;
		logic [4:0]  tx;
		logic [4:0]  rx;
		logic [4:0]  cf;
		v  = '0;
		tx = (s.twoWireMode & s.nack) | (~s.twoWireMode & s.txDone);
		rx = (s.twoWireMode & s.ack) | (~s.twoWireMode & s.rxDone);
		cf = (s.twoWireMode & s.startStop) | (~s.twoWireMode & s.busConflict);
		v[16:8]  = pe[16:8];
		v[17]    = tx[0];
		v[18]    = rx[0];
		v[19]    = tx[1];
		v[20]    = rx[1];
		v[32:21] = pe[32:21];
		v[33]    = tx[2];
		v[34]    = rx[2];
		v[35]    = tx[3];
		v[36]    = rx[3];
		v[37]    = tx[4];
		v[38]    = rx[4];
		v[39]    = cf[2];
		v[40]    = sel03 ? cf[3] : cf[0];
		v[41]    = sel14 ? cf[4] : cf[1];
		v[43:42] = pe[43:42];
		return v;
	endfunction

	logic [63:0] evVec;
	logic        nmiEdge;
	logic        supEdge;
	logic [7:0]  matchVec;
	logic        matchHit;
	logic        periWin;
	logic [5:0]  periNum;
	logic [2:0]  periLvl;
	logic        hwSlot;

	assign evVec    = mapEvents(periEvent, serialEvent, serial03VectorSelect, serial14VectorSelect);
	assign nmiEdge  = r.pinPrev & ~r.pinSync[1] & (r.primeCnt == isvl_pkg::PRIME_DONE);
	assign supEdge  = (r.supPrev ^ r.supSync[1]) & (r.primeCnt == isvl_pkg::PRIME_DONE);
	assign hwSlot   = instrBoundary && trapKind == isvl_pkg::TRAP_NONE;

	// comparators only see the first byte address of the next instruction
	genvar g;
	generate
		for (g = 0; g < isvl_pkg::NUM_MATCH; g++)
		begin : gMatch
			assign matchVec[g] = addrMatchEnableReg[g] && addrMatchTarget[g] == nextPc;
		end
	endgenerate
	assign matchHit = |matchVec;

	// highest level wins, lower number wins a tie
	always_comb
	begin
		periWin = 1'b0;
		periNum = isvl_pkg::VEC_PERI_FIRST;
		periLvl = isvl_pkg::LEVEL_OFF;
		for (int n = 8; n <= 43; n++)
		begin
			if (r.reqFlag[n] && sourcePriorityLevel[n] != isvl_pkg::LEVEL_OFF
				&& sourcePriorityLevel[n] > currentPriorityLevel
				&& (!periWin || sourcePriorityLevel[n] > periLvl))
			begin
				periWin = globalEnable;
				periNum = 6'(n);
				periLvl = sourcePriorityLevel[n];
			end
		end
	end

	always_comb
	begin
		rNext            = r;
		rNext.entryDone  = 1'b0;
		rNext.returnDone = 1'b0;
		rNext.pinSync    = {r.pinSync[0], extNmiPinN};
		rNext.pinPrev    = r.pinSync[1];
		rNext.supSync    = {r.supSync[0], supplyAboveThreshold};
		rNext.supPrev    = r.supSync[1];
		if (r.primeCnt != isvl_pkg::PRIME_DONE)
			rNext.primeCnt = r.primeCnt + 2'h1;
		rNext.dma23Off   = fastIrqSelect;

		// acknowledgement clears a flag; a new event in the same cycle wins
		rNext.reqFlag    = r.reqFlag & ~requestFlagClear;
		if (r.state == isvl_pkg::ST_IDLE && (instrBoundary || trapKind != isvl_pkg::TRAP_NONE))
		begin
			if (trapKind != isvl_pkg::TRAP_NONE)
			begin
				// instruction traps ignore the global enable and keep the level
				rNext.iplLoad = 1'b0;
				rNext.state   = isvl_pkg::ST_FETCH;
				rNext.memRd   = 1'b1;
				rNext.byteIdx = 2'h0;
				case (trapKind)
					isvl_pkg::TRAP_UNDEF:    rNext.memAddr = isvl_pkg::FIX_UNDEF;
					isvl_pkg::TRAP_OVERFLOW: rNext.memAddr = isvl_pkg::FIX_OVERFLOW;
					isvl_pkg::TRAP_BREAK:
					begin
						rNext.state   = isvl_pkg::ST_BRKCHK;
						rNext.memAddr = isvl_pkg::FIX_BREAK_TOP;
					end
					// software numbers 8..43 land on the peripheral entries
					default: rNext.memAddr = vectorBase + {16'h0000, trapNum, 2'b00};
				endcase
			end
			else if (r.nmiPend)
			begin
				rNext.nmiPend = nmiEdge;
				rNext.iplLoad = 1'b1;
				rNext.current_priority_level     = isvl_pkg::LEVEL_TOP;
				rNext.state   = isvl_pkg::ST_FETCH;
				rNext.memRd   = 1'b1;
				rNext.byteIdx = 2'h0;
				rNext.memAddr = isvl_pkg::FIX_EXT_NMI;
			end
			else if (r.wdtPend || r.oscPend || r.supPend)
			begin
				if (r.wdtPend)
				begin
					rNext.wdtPend      = watchdogUnderflow;
					rNext.specialCause = isvl_pkg::CAUSE_WDT;
				end
				else if (r.oscPend)
				begin
					rNext.oscPend      = mainClockLost;
					rNext.specialCause = isvl_pkg::CAUSE_OSC;
				end
				else
				begin
					rNext.supPend      = supEdge;
					rNext.specialCause = isvl_pkg::CAUSE_SUPPLY;
				end
				rNext.iplLoad = 1'b1;
				rNext.current_priority_level     = isvl_pkg::LEVEL_TOP;
				rNext.state   = isvl_pkg::ST_FETCH;
				rNext.memRd   = 1'b1;
				rNext.byteIdx = 2'h0;
				rNext.memAddr = isvl_pkg::FIX_SPECIAL;
			end
			else if (matchHit)
			begin
				rNext.iplLoad = 1'b0;
				rNext.state   = isvl_pkg::ST_FETCH;
				rNext.memRd   = 1'b1;
				rNext.byteIdx = 2'h0;
				rNext.memAddr = isvl_pkg::FIX_ADDR_MATCH;
			end
			else if (periWin && hwSlot)
			begin
				rNext.reqFlag[periNum] = 1'b0;
				rNext.iplLoad          = 1'b1;
				rNext.current_priority_level              = periLvl;
				if (fastIrqSelect && periLvl == isvl_pkg::LEVEL_TOP)
				begin
					rNext.savedFlags = flagIn;
					rNext.savedPc    = nextPc;
					rNext.target     = fastVector;
					rNext.state      = isvl_pkg::ST_FAST_IN;
					rNext.cnt        = 3'h1;
				end
				else
				begin
					rNext.state   = isvl_pkg::ST_FETCH;
					rNext.memRd   = 1'b1;
					rNext.byteIdx = 2'h0;
					rNext.memAddr = vectorBase + {16'h0000, periNum, 2'b00};
				end
			end
			else if (fastReturnInstr && instrBoundary)
			begin
				rNext.state = isvl_pkg::ST_FAST_OUT;
				rNext.cnt   = 3'h1;
			end
		end
		else
		begin
			case (r.state)
				isvl_pkg::ST_IDLE: ;
				isvl_pkg::ST_BRKCHK:
					if (memRdAck)
					begin
						rNext.byteIdx = 2'h0;
						rNext.state   = isvl_pkg::ST_FETCH;
						if (memRdata == isvl_pkg::BRK_UNSET)
							rNext.memAddr = vectorBase;
						else
							rNext.memAddr = isvl_pkg::FIX_BREAK;
					end
				isvl_pkg::ST_FETCH:
					if (memRdAck)
					begin
						// lowest address carries the least significant byte
						rNext.target = {memRdata, r.target[23:8]};
						if (r.byteIdx == 2'h3)
						begin
							rNext.target       = r.target;
							rNext.memRd        = 1'b0;
							rNext.state        = isvl_pkg::ST_IDLE;
							rNext.entryDone    = 1'b1;
							rNext.entryFast    = 1'b0;
							rNext.entryIplLoad = r.iplLoad;
							rNext.entryIpl     = r.current_priority_level;
						end
						else
						begin
							rNext.byteIdx = r.byteIdx + 2'h1;
							rNext.memAddr = r.memAddr + 24'h000001;
						end
					end
				isvl_pkg::ST_FAST_IN:
				begin
					rNext.cnt = r.cnt + 3'h1;
					if (r.cnt == isvl_pkg::FAST_ENTRY_CYC - 3'h1)
					begin
						rNext.state        = isvl_pkg::ST_IDLE;
						rNext.entryDone    = 1'b1;
						rNext.entryFast    = 1'b1;
						rNext.entryIplLoad = 1'b1;
						rNext.entryIpl     = r.current_priority_level;
					end
				end
				isvl_pkg::ST_FAST_OUT:
				begin
					rNext.cnt = r.cnt + 3'h1;
					if (r.cnt == isvl_pkg::FAST_RETURN_CYC - 3'h1)
					begin
						rNext.state      = isvl_pkg::ST_IDLE;
						rNext.returnDone = 1'b1;
					end
				end
				default: rNext.state = isvl_pkg::ST_IDLE;
			endcase
		end
		// source capture: set wins over the acknowledgement clear above
		rNext.reqFlag = rNext.reqFlag | evVec;
		if (nmiEdge)
			rNext.nmiPend = 1'b1;
		if (watchdogUnderflow)
			rNext.wdtPend = 1'b1;
		if (mainClockLost)
			rNext.oscPend = 1'b1;
		if (supEdge)
			rNext.supPend = 1'b1;
	end

	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
			r <= isvl_pkg::REGS_RESET;
		else
			r <= rNext;
	end

	assign memRdReq     = r.memRd;
	assign memAddr      = r.memAddr;
	assign busy         = r.state != isvl_pkg::ST_IDLE;
	assign entryDone    = r.entryDone;
	assign entryTarget  = r.target;
	assign entryFast    = r.entryFast;
	assign entryIplLoad = r.entryIplLoad;
	assign entryIpl     = r.entryIpl;
	assign specialCause = r.specialCause;
	assign returnDone   = r.returnDone;
	assign savedFlags   = r.savedFlags;
	assign savedPc      = r.savedPc;
	assign requestFlag  = r.reqFlag;
	assign dma23Disable = r.dma23Off;
endmodule

/* logic/isvl_pkg.sv */
// constants, carrier types and vector layout of the interrupt source and vector logic
// Function
// - external pin falling edge raises non-maskable request
// - watchdog underflow raises special request
// - main clock loss raises special request
// - supply threshold crossing either way raises request
// - enabled channel 0-7 traps before target instruction
// - match fires only on instruction first address
// - peripherals share vectors 8 to 43
// - fast entry five cycles, return three cycles
// - select bit makes level 7 fast
// - fast entry saves flags and pc, jumps
// - fast return restores flags and pc
// - fast mode blocks DMA channels 2 and 3
// - vectors are four-byte routine start addresses
// - fixed vector table layout from FFFFDCh
// - break top byte FFh uses relocatable zero
// - relocatable vector at base plus four n
// - relocatable numbers 8 to 25 mapping
// - relocatable numbers 26 to 63 mapping
// - break and traps ignore global enable
// - vectors 40/41 chosen by select bits
// - two-wire mode maps NACK, ACK, start/stop
// - maskable accept: enable, flag, level above current
// - special acknowledgement sets current level seven
package isvl_pkg;
	localparam int          ADDR_W         = 24;
	localparam int          FLAG_W         = 16;
	localparam int          NUM_MATCH      = 8;
	localparam logic [23:0] FIX_UNDEF      = 24'hffffdc;
	localparam logic [23:0] FIX_OVERFLOW   = 24'hffffe0;
	localparam logic [23:0] FIX_BREAK      = 24'hffffe4;
	localparam logic [23:0] FIX_BREAK_TOP  = 24'hffffe7;
	localparam logic [23:0] FIX_ADDR_MATCH = 24'hffffe8;
	localparam logic [23:0] FIX_SPECIAL    = 24'hfffff0;
	localparam logic [23:0] FIX_EXT_NMI    = 24'hfffff8;
	localparam logic [7:0]  BRK_UNSET      = 8'hff;
	localparam logic [5:0]  VEC_PERI_FIRST = 6'h08;
	localparam logic [5:0]  VEC_PERI_LAST  = 6'h2b;
	localparam logic [5:0]  VEC_CONFLICT2  = 6'h27;
	localparam logic [5:0]  VEC_CONFLICT03 = 6'h28;
	localparam logic [5:0]  VEC_CONFLICT14 = 6'h29;
	localparam logic [2:0]  LEVEL_OFF      = 3'h0;
	localparam logic [2:0]  LEVEL_TOP      = 3'h7;
	localparam logic [2:0]  FAST_ENTRY_CYC = 3'h5;
	localparam logic [2:0]  FAST_RETURN_CYC = 3'h3;
	localparam logic [1:0]  PRIME_DONE     = 2'h3;
	localparam logic [1:0]  CAUSE_WDT      = 2'h0;
	localparam logic [1:0]  CAUSE_OSC      = 2'h1;
	localparam logic [1:0]  CAUSE_SUPPLY   = 2'h2;

	typedef enum logic [2:0] {ST_IDLE, ST_BRKCHK, ST_FETCH, ST_FAST_IN, ST_FAST_OUT} isvl_state_t;
	typedef enum logic [2:0] {TRAP_NONE, TRAP_UNDEF, TRAP_OVERFLOW, TRAP_BREAK, TRAP_INT}
		isvl_trap_t;

	// serial units 0..4 event lines, bit u belongs to unit u
	typedef struct packed {
		logic [4:0] txDone;
		logic [4:0] rxDone;
		logic [4:0] nack;
		logic [4:0] ack;
		logic [4:0] busConflict;
		logic [4:0] startStop;
		logic [4:0] twoWireMode;
	} isvl_serial_t;

	typedef struct packed {
		logic [1:0]        pinSync;
		logic              pinPrev;
		logic [1:0]        supSync;
		logic              supPrev;
		logic [1:0]        primeCnt;
		logic              nmiPend;
		logic              wdtPend;
		logic              oscPend;
		logic              supPend;
		logic [63:0]       reqFlag;
		isvl_state_t       state;
		logic [2:0]        cnt;
		logic [1:0]        byteIdx;
		logic              memRd;
		logic [23:0]       memAddr;
		logic [23:0]       target;
		logic              iplLoad;
		logic [2:0]        current_priority_level;
		logic              entryDone;
		logic              entryFast;
		logic              entryIplLoad;
		logic [2:0]        entryIpl;
		logic [1:0]        specialCause;
		logic              returnDone;
		logic [FLAG_W-1:0] savedFlags;
		logic [23:0]       savedPc;
		logic              dma23Off;
	} isvl_regs_t;

	localparam isvl_regs_t REGS_RESET = '0;
endpackage

/* bench/isvl_vec_mem.sv */
// byte-wide vector memory model answering the fetch port after a chosen delay
`timescale 1ns/1ps
module isvl_vec_mem (
	// clock and reset
	input wire logic        core_clk,
	input wire logic        rstn,
	// fetch port
	input wire logic        memRdReq,
	input wire logic [23:0] memAddr,
	output logic [7:0]      memRdata,
	output logic            memRdAck,
	// behaviour
	input wire logic [7:0]  brkTop,
	input wire logic [1:0]  delay
);
	logic [1:0] waitCnt;
	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			memRdAck <= 1'b0;
			memRdata <= 8'h00;
			waitCnt  <= 2'h0;
		end
		else if (memRdReq && !memRdAck && waitCnt == delay)
		begin
			memRdAck <= 1'b1;
			// entries little endian, top byte of the break entry settable
			memRdata <= (memAddr == isvl_pkg::FIX_BREAK_TOP) ? brkTop : memAddr[7:0] ^ 8'h3c;
			waitCnt  <= 2'h0;
		end
		else
		begin
			// released data is inverted so a late sample shows up
			if (memRdAck)
				memRdata <= ~memRdata;
			memRdAck <= 1'b0;
			waitCnt  <= (memRdReq && !memRdAck) ? waitCnt + 2'h1 : 2'h0;
		end
	end
endmodule

/* bench/isvl_core_asserts.sv */
// concurrent checks on the ports of the interrupt source and vector logic
`timescale 1ns/1ps
module isvl_core_asserts (
	// clock and reset
	input wire logic        core_clk,
	input wire logic        rstn,
	// fast controls
	input wire logic        fastIrqSelect,
	input wire logic [23:0] fastVector,
	// vector fetch
	input wire logic        memRdReq,
	input wire logic [23:0] memAddr,
	input wire logic        memRdAck,
	// results
	input wire logic        busy,
	input wire logic        entryDone,
	input wire logic [23:0] entryTarget,
	input wire logic        entryFast,
	input wire logic        entryIplLoad,
	input wire logic [2:0]  entryIpl,
	input wire logic        returnDone,
	input wire logic        dma23Disable
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rstn);
	sequence s_lastByte(logic [23:0] a);
		memRdReq && memRdAck && memAddr == a + 24'h3;
	endsequence
	sequence s_waitAck;
		memRdReq && !memRdAck;
	endsequence
	property p_fastTarget;
		entryDone && entryFast |-> entryTarget == fastVector;
	endproperty
	property p_fastEntryTime;
		entryDone && entryFast |-> $past(busy, 1) && $past(busy, 4) && !$past(busy, 5);
	endproperty
	property p_fastReturnTime;
		returnDone |-> $past(busy, 1) && $past(busy, 2) && !$past(busy, 3);
	endproperty
	property p_dmaOn;
		fastIrqSelect [*2] |-> dma23Disable;
	endproperty
	property p_dmaOff;
		!fastIrqSelect [*2] |-> !dma23Disable;
	endproperty
	property p_fetchHold;
		s_waitAck |=> memRdReq && $stable(memAddr);
	endproperty
	property p_idleNoFetch;
		!busy |-> !memRdReq;
	endproperty
	property p_specialLevel;
		(s_lastByte(isvl_pkg::FIX_SPECIAL) or s_lastByte(isvl_pkg::FIX_EXT_NMI))
			|=> entryDone && entryIplLoad && entryIpl == 3'h7;
	endproperty
	property p_trapNoLevel;
		(s_lastByte(isvl_pkg::FIX_UNDEF) or s_lastByte(isvl_pkg::FIX_ADDR_MATCH))
			|=> entryDone && !entryIplLoad;
	endproperty
	a_fastTarget: assert property (p_fastTarget) else $error("fast target wrong");
	a_fastEntryTime: assert property (p_fastEntryTime) else $error("fast entry time");
	a_fastReturnTime: assert property (p_fastReturnTime) else $error("fast return time");
	a_dmaOn: assert property (p_dmaOn) else $error("dma 2/3 not blocked");
	a_dmaOff: assert property (p_dmaOff) else $error("dma 2/3 blocked");
	a_fetchHold: assert property (p_fetchHold) else $error("fetch dropped early");
	a_idleNoFetch: assert property (p_idleNoFetch) else $error("fetch while idle");
	a_specialLevel: assert property (p_specialLevel) else $error("level not 7");
	a_trapNoLevel: assert property (p_trapNoLevel) else $error("level loaded");
endmodule
bind isvl_core isvl_core_asserts u_chk (.core_clk, .rstn, .fastIrqSelect, .fastVector,
	.memRdReq, .memAddr, .memRdAck, .busy, .entryDone, .entryTarget, .entryFast,
	.entryIplLoad, .entryIpl, .returnDone, .dma23Disable);

/* bench/tb_top.sv */
// self-checking bench for the interrupt source and vector logic
`timescale 1ns/1ps
module tb_top;
	logic                         core_clk;
	logic                         rstn = 1'b0;
	logic                         extNmiPinN = 1'b1;
	logic                         supplyAboveThreshold = 1'b1;
	logic                         watchdogUnderflow = 1'b0;
	logic                         mainClockLost = 1'b0;
	logic [63:0]                  periEvent = '0;
	isvl_pkg::isvl_serial_t       serialEvent = '0;
	logic [43:8][2:0]             sourcePriorityLevel = {36{3'h2}};
	logic [63:0]                  requestFlagClear = '0;
	logic                         serial03VectorSelect = 1'b0;
	logic                         serial14VectorSelect = 1'b0;
	logic                         fastIrqSelect = 1'b0;
	logic [23:0]                  vectorBase = 24'h012300; // even base
	logic [23:0]                  fastVector = 24'h0456a0;
	logic [7:0]                   addrMatchEnableReg = '0;
	logic [7:0][23:0]             addrMatchTarget = '0;
	logic                         instrBoundary = 1'b0;
	logic [23:0]                  nextPc = '0;
	isvl_pkg::isvl_trap_t         trapKind = isvl_pkg::TRAP_NONE;
	logic [5:0]                   trapNum = '0;
	logic                         globalEnable = 1'b0;
	logic [2:0]                   currentPriorityLevel = '0;
	logic [isvl_pkg::FLAG_W-1:0]  flagIn = '0;
	logic                         fastReturnInstr = 1'b0;
	logic                         memRdReq, memRdAck, busy, entryDone, entryFast;
	logic                         entryIplLoad, returnDone, dma23Disable;
	logic [23:0]                  memAddr, entryTarget, savedPc;
	logic [7:0]                   memRdata;
	logic [2:0]                   entryIpl;
	logic [1:0]                   specialCause;
	logic [isvl_pkg::FLAG_W-1:0]  savedFlags;
	logic [63:0]                  requestFlag;
	logic [7:0]                   brkTop = 8'h12;
	logic [1:0]                   delay = 2'h0;
	logic [28:0]                  expQ[$];
	int                           num_errors = 0;
	int                           tests_run = 0;
	int                           retCnt = 0;
	int                           n;
	int                           u;

	isvl_core uut (.*);
	isvl_vec_mem partner (.*);

	function automatic logic [23:0] vt(logic [23:0] a);
		return {8'(a + 24'h2) ^ 8'h3c, 8'(a + 24'h1) ^ 8'h3c, a[7:0] ^ 8'h3c};
	endfunction
	function automatic logic [28:0] ex(logic ld, logic [2:0] l, logic f, logic [23:0] t);
		return {ld, ld ? l : 3'h0, f, t};
	endfunction
	task automatic check(logic [63:0] seen, logic [63:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task finish_test;
		$display("comparisons %0d mismatches %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic step(isvl_pkg::isvl_trap_t k, int t, logic [23:0] pc, logic [28:0] e, bit w);
		int i;
		if (w)
			expQ.push_back(e);
		@(negedge core_clk);
		delay = 2'($urandom_range(2));
		{trapKind, trapNum, nextPc, instrBoundary} = {k, 6'(t), pc, 1'b1};
		@(negedge core_clk);
		{trapKind, instrBoundary} = {isvl_pkg::TRAP_NONE, 1'b0};
		for (i = 0; i < 80 && (expQ.size() != 0 || busy !== 1'b0); i++)
			@(negedge core_clk);
		if (i == 80)
			check(1, 0);
		@(negedge core_clk);
	endtask
	task automatic evt(int v);
		@(negedge core_clk) periEvent[v] = 1'b1;
		@(negedge core_clk) periEvent = '0;
	endtask
	// kind 0 transmit or nack, 1 receive or ack, 2 conflict or start/stop; odd units two-wire
	task automatic sev(int v, int k, int num);
		@(negedge core_clk) serialEvent.twoWireMode[v] = v[0];
		serialEvent.nack[v] = (k == 0) & v[0];
		serialEvent.txDone[v] = (k == 0) & !v[0];
		serialEvent.ack[v] = (k == 1) & v[0];
		serialEvent.rxDone[v] = (k == 1) & !v[0];
		serialEvent.startStop[v] = (k == 2) & v[0];
		serialEvent.busConflict[v] = (k == 2) & !v[0];
		@(negedge core_clk) serialEvent = '0;
		step(isvl_pkg::TRAP_NONE, 0, 24'h1000, ex(1, 2, 0, vt(vectorBase + 24'(4 * num))), 1);
	endtask

	always @(posedge core_clk)
	begin
		if (rstn && entryDone === 1'b1)
		begin
			if (expQ.size() == 0)
				check(1, 0);
			else
				check({entryIplLoad, entryIplLoad ? entryIpl : 3'h0, entryFast, entryTarget},
					expQ.pop_front());
		end
		if (rstn && returnDone === 1'b1)
			retCnt++;
	end
	initial
	begin
		core_clk = 1'b0;
		forever #10 core_clk = ~core_clk;
	end
	initial
	begin
		#600000;
		num_errors++;
		finish_test;
	end
	initial
	begin
		void'($urandom(32'h2f83));
		repeat (12) @(negedge core_clk);
		rstn = 1'b1;
		repeat (4) @(negedge core_clk);
		step(isvl_pkg::TRAP_UNDEF, 0, 24'h100, ex(0, 0, 0, vt(isvl_pkg::FIX_UNDEF)), 1);
		step(isvl_pkg::TRAP_OVERFLOW, 0, 24'h104, ex(0, 0, 0, vt(isvl_pkg::FIX_OVERFLOW)), 1);
		step(isvl_pkg::TRAP_BREAK, 0, 24'h108, ex(0, 0, 0, vt(isvl_pkg::FIX_BREAK)), 1);
		brkTop = isvl_pkg::BRK_UNSET;
		step(isvl_pkg::TRAP_BREAK, 0, 24'h10c, ex(0, 0, 0, vt(vectorBase)), 1);
		for (n = 0; n < 64; n++)
			step(isvl_pkg::TRAP_INT, n, 24'($urandom), ex(0, 0, 0, vt(vectorBase + 24'(4 * n))), 1);
		$display("trap tests done");
		@(negedge core_clk) watchdogUnderflow = 1'b1;
		@(negedge core_clk) watchdogUnderflow = 1'b0;
		step(isvl_pkg::TRAP_NONE, 0, 24'h200, ex(1, 7, 0, vt(isvl_pkg::FIX_SPECIAL)), 1);
		check(specialCause, isvl_pkg::CAUSE_WDT);
		@(negedge core_clk) mainClockLost = 1'b1;
		@(negedge core_clk) mainClockLost = 1'b0;
		step(isvl_pkg::TRAP_NONE, 0, 24'h204, ex(1, 7, 0, vt(isvl_pkg::FIX_SPECIAL)), 1);
		check(specialCause, isvl_pkg::CAUSE_OSC);
		for (n = 0; n < 2; n++)
		begin
			@(negedge core_clk) supplyAboveThreshold = ~supplyAboveThreshold;
			repeat (4) @(negedge core_clk);
			step(isvl_pkg::TRAP_NONE, 0, 24'h208, ex(1, 7, 0, vt(isvl_pkg::FIX_SPECIAL)), 1);
			check(specialCause, isvl_pkg::CAUSE_SUPPLY);
		end
		extNmiPinN = 1'b0;
		repeat (4) @(negedge core_clk);
		step(isvl_pkg::TRAP_NONE, 0, 24'h20c, ex(1, 7, 0, vt(isvl_pkg::FIX_EXT_NMI)), 1);
		step(isvl_pkg::TRAP_NONE, 0, 24'h210, 0, 0);
		extNmiPinN = 1'b1;
		repeat (4) @(negedge core_clk);
		step(isvl_pkg::TRAP_NONE, 0, 24'h214, 0, 0);
		$display("special source tests done");
		for (n = 0; n < 8; n++)
		begin
			addrMatchEnableReg = 8'h01 << n;
			addrMatchTarget[n] = 24'($urandom);
			step(isvl_pkg::TRAP_NONE, 0, addrMatchTarget[n], ex(0, 0, 0, vt(isvl_pkg::FIX_ADDR_MATCH)), 1);
			step(isvl_pkg::TRAP_NONE, 0, addrMatchTarget[n] + 24'h1, 0, 0);
		end
		addrMatchEnableReg = '0;
		step(isvl_pkg::TRAP_NONE, 0, addrMatchTarget[7], 0, 0);
		$display("address match tests done");
		globalEnable = 1'b1;
		for (n = 8; n < 44; n++)
		begin
			if (n < 17 || (n > 20 && n < 33) || n > 41)
			begin
				sourcePriorityLevel[n] = 3'($urandom_range(6, 1));
				evt(n);
				step(isvl_pkg::TRAP_NONE, 0, 24'h300, ex(1, sourcePriorityLevel[n], 0, vt(vectorBase + 24'(4 * n))), 1);
				check(requestFlag[n], 0);
				sourcePriorityLevel[n] = 3'h2;
			end
		end
		for (u = 0; u < 5; u++)
		begin
			sev(u, 0, u < 2 ? 17 + 2 * u : 29 + 2 * u);
			sev(u, 1, u < 2 ? 18 + 2 * u : 30 + 2 * u);
		end
		sev(2, 2, 39);
		for (n = 0; n < 2; n++)
		begin
			{serial03VectorSelect, serial14VectorSelect} = {n[0], n[0]};
			sev(n ? 3 : 0, 2, 40);
			sev(n ? 4 : 1, 2, 41);
		end
		currentPriorityLevel = 3'h2;
		evt(12);
		step(isvl_pkg::TRAP_NONE, 0, 24'h400, 0, 0);
		currentPriorityLevel = 3'h1;
		step(isvl_pkg::TRAP_NONE, 0, 24'h404, ex(1, 2, 0, vt(vectorBase + 24'd48)), 1);
		{globalEnable, currentPriorityLevel} = 4'h0;
		evt(12);
		step(isvl_pkg::TRAP_NONE, 0, 24'h408, 0, 0);
		globalEnable = 1'b1;
		step(isvl_pkg::TRAP_NONE, 0, 24'h40c, ex(1, 2, 0, vt(vectorBase + 24'd48)), 1);
		sourcePriorityLevel[12] = isvl_pkg::LEVEL_OFF;
		evt(12);
		step(isvl_pkg::TRAP_NONE, 0, 24'h410, 0, 0);
		@(negedge core_clk) requestFlagClear = '1;
		@(negedge core_clk) requestFlagClear = '0;
		check(requestFlag, 0);
		$display("peripheral tests done");
		// only this source ever sits at level 7; no chained transfer on that level
		sourcePriorityLevel[15] = isvl_pkg::LEVEL_TOP;
		evt(15);
		step(isvl_pkg::TRAP_NONE, 0, 24'h500, ex(1, 7, 0, vt(vectorBase + 24'd60)), 1);
		check(dma23Disable, 0);
		fastIrqSelect = 1'b1;
		flagIn = 16'($urandom);
		evt(15);
		step(isvl_pkg::TRAP_NONE, 0, 24'h0abcde, ex(1, 7, 1, fastVector), 1);
		check({savedFlags, savedPc}, {flagIn, 24'h0abcde});
		check(dma23Disable, 1);
		flagIn = ~flagIn;
		fastReturnInstr = 1'b1;
		step(isvl_pkg::TRAP_NONE, 0, 24'h600, 0, 0);
		fastReturnInstr = 1'b0;
		check({retCnt[7:0], savedFlags, savedPc}, {8'h01, ~flagIn, 24'h0abcde});
		$display("fast interrupt tests done");
		finish_test;
	end
endmodule
